// File: logic/ehm_map.svh
// Offsets, field positions, reset values and widths of the multiplier tile.
// Included by the tile top; holds definitions only.
`ifndef EHM_MAP_SVH
`define EHM_MAP_SVH

// Wide and narrow operand widths
`define EHM_WIDE_W 18
`define EHM_NARROW_W 9

// AXI4-Lite register offsets (byte addresses)
`define EHM_ADDR_W 4
`define EHM_OFF_CTRL 4'h0
`define EHM_OFF_RES_LO 4'h4
`define EHM_OFF_RES_HI 4'h8

// Control register fields
`define EHM_CTRL_W 7
`define EHM_CTRL_RESET 7'h00
`define EHM_CTRL_MODE 0
`define EHM_CTRL_REG_A 1
`define EHM_CTRL_REG_B 2
`define EHM_CTRL_REG_SIGNA 3
`define EHM_CTRL_REG_SIGNB 4
`define EHM_CTRL_REG_RES 5
`define EHM_CTRL_SIGN_USED 6

// Upper result word: sign flag position
`define EHM_HI_SIGN_BIT 8

// Bus responses
`define EHM_RESP_OKAY 2'h0
`define EHM_RESP_SLVERR 2'h2

`endif

// File: logic/ehm_opt_reg.sv
// One bypassable register stage of the multiplier tile.
// Assumes clock, enable and clear are the tile's shared controls.
module ehm_opt_reg #(
   parameter int W = 1
) (
   // Shared tile controls
   input wire logic clk,
   input wire logic ce,
   input wire logic clear,
   // Path select and data
   input wire logic use_reg,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] r;

   // Clear acts without the clock; enable low holds
   always_ff @(posedge clk or posedge clear) begin
      if (clear) begin
         r <= '0;
      end else if (ce) begin
         r <= d;
      end
   end

   assign q = use_reg ? r : d;

   a_stage_hold: assert property (@(posedge clk) disable iff (clear)
      !ce |=> r == $past(r))
      else $error("register stage changed with enable low");

endmodule

// File: logic/ehm_pkg.sv
// Types shared by the multiplier tile files.
// Field order of the config struct matches the control register bits.
package ehm_pkg;

   typedef enum logic {
      EHM_MODE_WIDE,
      EHM_MODE_DUAL
   } ehm_mode_e;

   // Bit 6 down to bit 0 of the control register
   typedef struct packed {
      logic sign_used;
      logic reg_result;
      logic reg_signb;
      logic reg_signa;
      logic reg_b;
      logic reg_a;
      ehm_mode_e mode;
   } ehm_cfg_s;

endpackage

// File: logic/ehm_top.sv
// Configurable hard multiplier tile: one wide or two narrow products.
// Operands and sign controls come from fabric logic on aclk; the
// mode and path selects are set over AXI4-Lite.
`include "ehm_map.svh"

module ehm_top #(
   parameter int WIDE_W = `EHM_WIDE_W
) (
   // Clock and bus reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [`EHM_ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // AXI4-Lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // AXI4-Lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read address
   input wire logic [`EHM_ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   // AXI4-Lite read data
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Shared tile register controls
   input wire logic ce,
   input wire logic clear,
   // Operands from fabric
   input wire logic signa,
   input wire logic signb,
   input wire logic [WIDE_W-1:0] data_a,
   input wire logic [WIDE_W-1:0] data_b,
   // Products to fabric
   output logic [2*WIDE_W-1:0] result,
   output logic result_signed
);

   localparam int NW = WIDE_W / 2;
   localparam int RW = 2 * WIDE_W;

   logic [`EHM_CTRL_W-1:0] ctrl;
   ehm_pkg::ehm_cfg_s cfg;
   logic aw_full;
   logic w_full;
   logic [`EHM_ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic do_write;
   logic wr_hit;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   logic [WIDE_W-1:0] a_q;
   logic [WIDE_W-1:0] b_q;
   logic sa_q;
   logic sb_q;
   logic ua;
   logic ub;
   logic signed [RW+1:0] prod_wide;
   logic signed [2*NW+1:0] prod_lo;
   logic signed [2*NW+1:0] prod_hi;
   logic [RW-1:0] prod;

   assign cfg = ehm_pkg::ehm_cfg_s'(ctrl);

   // Write side: address and data are latched in either order
   assign awready = !aw_full;
   assign wready = !w_full;
   assign do_write = aw_full && w_full && !bvalid;
   assign wr_hit = (aw_addr_q == `EHM_OFF_CTRL);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         aw_addr_q <= '0;
      end else if (do_write) begin
         aw_full <= 1'b0;
      end else if (awvalid && awready) begin
         aw_full <= 1'b1;
         aw_addr_q <= awaddr;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else if (do_write) begin
         w_full <= 1'b0;
      end else if (wvalid && wready) begin
         w_full <= 1'b1;
         w_data_q <= wdata;
         w_strb_q <= wstrb;
      end
   end

   // Result words are read-only; a write there is refused
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= `EHM_RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp <= wr_hit ? `EHM_RESP_OKAY : `EHM_RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Mode and path selects; all fields sit in byte lane 0
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= `EHM_CTRL_RESET;
      end else if (do_write && wr_hit && w_strb_q[0]) begin
         ctrl <= w_data_q[`EHM_CTRL_W-1:0];
      end
   end

   // Read decode
   always_comb begin
      next_rdata = '0;
      next_rresp = `EHM_RESP_OKAY;
      if (araddr == `EHM_OFF_CTRL) begin
         next_rdata[`EHM_CTRL_W-1:0] = ctrl;
      end else if (araddr == `EHM_OFF_RES_LO) begin
         next_rdata = result[31:0];
      end else if (araddr == `EHM_OFF_RES_HI) begin
         next_rdata[RW-33:0] = result[RW-1:32];
         next_rdata[`EHM_HI_SIGN_BIT] = result_signed;
      end else begin
         next_rresp = `EHM_RESP_SLVERR;
      end
   end

   assign arready = !rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= `EHM_RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // Input stages: each operand and sign has its own path select
   ehm_opt_reg #(.W(WIDE_W)) u_reg_a (
      .clk(aclk),
      .ce(ce),
      .clear(clear),
      .use_reg(cfg.reg_a),
      .d(data_a),
      .q(a_q)
   );

   ehm_opt_reg #(.W(WIDE_W)) u_reg_b (
      .clk(aclk),
      .ce(ce),
      .clear(clear),
      .use_reg(cfg.reg_b),
      .d(data_b),
      .q(b_q)
   );

   ehm_opt_reg #(.W(1)) u_reg_signa (
      .clk(aclk),
      .ce(ce),
      .clear(clear),
      .use_reg(cfg.reg_signa),
      .d(signa),
      .q(sa_q)
   );

   ehm_opt_reg #(.W(1)) u_reg_signb (
      .clk(aclk),
      .ce(ce),
      .clear(clear),
      .use_reg(cfg.reg_signb),
      .d(signb),
      .q(sb_q)
   );

   // One sign per operand bus, so both narrow lanes share it
   assign ua = cfg.sign_used & sa_q;
   assign ub = cfg.sign_used & sb_q;

   // One extra bit lets a single signed multiply cover both meanings
   assign prod_wide = $signed({ua & a_q[WIDE_W-1], a_q})
                    * $signed({ub & b_q[WIDE_W-1], b_q});
   assign prod_lo = $signed({ua & a_q[NW-1], a_q[NW-1:0]})
                  * $signed({ub & b_q[NW-1], b_q[NW-1:0]});
   assign prod_hi = $signed({ua & a_q[WIDE_W-1], a_q[WIDE_W-1:NW]})
                  * $signed({ub & b_q[WIDE_W-1], b_q[WIDE_W-1:NW]});

   always_comb begin
      if (cfg.mode == ehm_pkg::EHM_MODE_DUAL) begin
         prod = {prod_hi[2*NW-1:0], prod_lo[2*NW-1:0]};
      end else begin
         prod = prod_wide[RW-1:0];
      end
   end

   // Sign flag travels with the product through the same stage
   ehm_opt_reg #(.W(RW + 1)) u_reg_res (
      .clk(aclk),
      .ce(ce),
      .clear(clear),
      .use_reg(cfg.reg_result),
      .d({ua | ub, prod}),
      .q({result_signed, result})
   );

   // Reference products straight from the ports, for the checks below
   logic signed [RW+1:0] ref_wide;
   logic signed [2*NW+1:0] ref_lo;
   logic signed [2*NW+1:0] ref_hi;
   logic [RW-1:0] ref_wide_t;
   logic [RW-1:0] ref_dual;
   logic byp_all;
   logic reg_all;
   logic port_signed;

   assign ref_wide = $signed({cfg.sign_used & signa & data_a[WIDE_W-1],
      data_a}) * $signed({cfg.sign_used & signb & data_b[WIDE_W-1],
      data_b});
   assign ref_lo = $signed({cfg.sign_used & signa & data_a[NW-1],
      data_a[NW-1:0]}) * $signed({cfg.sign_used & signb & data_b[NW-1],
      data_b[NW-1:0]});
   assign ref_hi = $signed({cfg.sign_used & signa & data_a[WIDE_W-1],
      data_a[WIDE_W-1:NW]}) * $signed({cfg.sign_used & signb
      & data_b[WIDE_W-1], data_b[WIDE_W-1:NW]});
   assign ref_wide_t = ref_wide[RW-1:0];
   assign ref_dual = {ref_hi[2*NW-1:0], ref_lo[2*NW-1:0]};
   assign byp_all = !cfg.reg_a && !cfg.reg_b && !cfg.reg_signa
      && !cfg.reg_signb && !cfg.reg_result;
   assign reg_all = cfg.reg_a && cfg.reg_b && cfg.reg_signa
      && cfg.reg_signb && cfg.reg_result;
   assign port_signed = cfg.sign_used && (signa || signb);

   a_wide_direct: assert property (@(posedge aclk) disable iff (!aresetn)
      byp_all && cfg.mode == ehm_pkg::EHM_MODE_WIDE |-> result == ref_wide_t)
      else $error("wide product differs from operands");

   a_dual_lanes: assert property (@(posedge aclk) disable iff (!aresetn)
      byp_all && cfg.mode == ehm_pkg::EHM_MODE_DUAL
      |-> result[2*NW-1:0] == ref_lo[2*NW-1:0]
      && result[RW-1:2*NW] == ref_hi[2*NW-1:0])
      else $error("narrow lane products wrong");

   a_sign_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      byp_all |-> result_signed == port_signed)
      else $error("result sign flag wrong");

   a_unsigned_dflt: assert property (@(posedge aclk)
      disable iff (!aresetn)
      byp_all && !cfg.sign_used |-> !result_signed
      && result == {{WIDE_W{1'b0}}, data_a} * {{WIDE_W{1'b0}}, data_b})
      else $error("unused signs did not give unsigned product");

   a_clear_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      clear && cfg.reg_result |-> result == '0 && !result_signed)
      else $error("clear did not zero the result");

   a_ce_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      (!ce && !clear && cfg.reg_result) ##1 (!clear && cfg.reg_result)
      |-> $stable(result) && $stable(result_signed))
      else $error("result moved with enable low");

   a_two_stage: assert property (@(posedge aclk) disable iff (!aresetn)
      reg_all && cfg.mode == ehm_pkg::EHM_MODE_WIDE && !clear
      && $past(ce) && $past(ce, 2) && !$past(clear) && !$past(clear, 2)
      && ctrl == $past(ctrl) && ctrl == $past(ctrl, 2)
      |-> result == $past(ref_wide_t, 2))
      else $error("registered product not two cycles after operands");

   // Result stage alone: one cycle from operands to both lane products
   a_dual_reg: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg.mode == ehm_pkg::EHM_MODE_DUAL && cfg.reg_result && !cfg.reg_a
      && !cfg.reg_b && !cfg.reg_signa && !cfg.reg_signb && $past(ce)
      && !clear && !$past(clear) && ctrl == $past(ctrl)
      |-> result == $past(ref_dual)
      && result_signed == $past(port_signed))
      else $error("registered narrow products wrong");

   a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped before taken");

   a_strb_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && !w_strb_q[0] |=> $stable(ctrl))
      else $error("control changed without its byte strobe");

   a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      arvalid && arready && araddr != `EHM_OFF_CTRL
      && araddr != `EHM_OFF_RES_LO && araddr != `EHM_OFF_RES_HI
      |=> rvalid && rresp == `EHM_RESP_SLVERR)
      else $error("unmapped read not refused next cycle");

   c_dual_signed: cover property (@(posedge aclk) disable iff (!aresetn)
      cfg.mode == ehm_pkg::EHM_MODE_DUAL && result_signed);

   c_wide_reg: cover property (@(posedge aclk) disable iff (!aresetn)
      reg_all && cfg.mode == ehm_pkg::EHM_MODE_WIDE && ce ##1 ce);

   c_ce_stall: cover property (@(posedge aclk) disable iff (!aresetn)
      cfg.reg_result && !ce ##1 !ce);

   c_bad_read: cover property (@(posedge aclk) disable iff (!aresetn)
      rvalid && rresp == `EHM_RESP_SLVERR);

   c_dual_reg: cover property (@(posedge aclk) disable iff (!aresetn)
      cfg.mode == ehm_pkg::EHM_MODE_DUAL && cfg.reg_result && ce ##1 ce);

endmodule

// File: verif/ehm_fabric_model.sv
// Fabric logic model that feeds operands and sign controls to the tile.
// Assumes the bench calls drive(); values change just after a rising edge.
module ehm_fabric_model #(
   parameter int W = 18
) (
   // Fabric clock
   input wire logic aclk,
   // Operands and sign controls to the tile
   output logic [W-1:0] data_a,
   output logic [W-1:0] data_b,
   output logic signa,
   output logic signb
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      data_a = '0;
      data_b = '0;
      signa = 1'b0;
      signb = 1'b0;
   end

   // One sign pair only, so both lanes always share a representation
   task automatic drive(input logic [W-1:0] a, b, input logic sa, sb);
      @(posedge aclk);
      data_a <= a;
      data_b <= b;
      signa <= sa;
      signb <= sb;
   endtask
endmodule

// File: verif/testbench.sv
// Self-checking bench for the multiplier tile: AXI4-Lite setup, then
// operand traffic from the fabric model against worked-out products.
// Assumes ehm_top and ehm_fabric_model are compiled before it.
`include "ehm_map.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [17:0] a1 = 18'h3fffe;
   localparam logic [17:0] b1 = 18'h20003;
   localparam logic [17:0] a2 = {9'h1ff, 9'h101};
   localparam logic [17:0] b2 = {9'h003, 9'h1fe};
   localparam logic [1:0] ok = `EHM_RESP_OKAY;
   localparam logic [1:0] err = `EHM_RESP_SLVERR;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, ce = 1'b1, clear = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic signa, signb, result_signed;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [17:0] data_a, data_b;
   logic [35:0] result, p;
   int bad_count = 0;
   int n_checks = 0;
   int i;

   always #25 aclk = ~aclk;

   ehm_top dut_u (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .ce(ce), .clear(clear), .signa(signa), .signb(signb),
      .data_a(data_a), .data_b(data_b), .result(result),
      .result_signed(result_signed));

   ehm_fabric_model fab_u (.aclk(aclk), .data_a(data_a), .data_b(data_b),
      .signa(signa), .signb(signb));

   function automatic logic [35:0] wp(logic [17:0] a, b, logic sa, sb);
      logic signed [35:0] x;
      logic signed [35:0] y;
      x = sa ? {{18{a[17]}}, a} : {18'h0, a};
      y = sb ? {{18{b[17]}}, b} : {18'h0, b};
      return 36'(x * y);
   endfunction

   function automatic logic [17:0] np(logic [8:0] a, b, logic sa, sb);
      logic signed [17:0] x;
      logic signed [17:0] y;
      x = sa ? {{9{a[8]}}, a} : {9'h0, a};
      y = sb ? {{9{b[8]}}, b} : {9'h0, b};
      return 18'(x * y);
   endfunction

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [35:0] g, e);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                         input logic [1:0] er);
      int k;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 40; k++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (k == 40) begin
         bad_count++;
         report_and_stop();
      end
      chk(36'(bresp), 36'(er));
   endtask

   task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed,
                         input logic [1:0] er);
      int k;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 40; k++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         d = rdata;
         r = rresp;
         if (rvalid) break;
      end
      rready <= 1'b0;
      if (k == 40) begin
         bad_count++;
         report_and_stop();
      end
      chk(36'(d), 36'(ed));
      chk(36'(r), 36'(er));
   endtask

   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(`EHM_OFF_CTRL, 32'h0, ok);
      // Sign inputs high but ignored while the controls are unused
      fab_u.drive(18'h3ffff, 18'h3ffff, 1'b1, 1'b1);
      #1;
      chk(result, wp(18'h3ffff, 18'h3ffff, 1'b0, 1'b0));
      chk(36'(result_signed), 36'h0);
      axi_wr(`EHM_OFF_CTRL, 32'h40, ok);
      for (i = 0; i < 4; i++) begin
         fab_u.drive(a1, b1, i[1], i[0]);
         #1;
         chk(result, wp(a1, b1, i[1], i[0]));
         chk(36'(result_signed), 36'(i[1] | i[0]));
      end
      p = wp(a1, b1, 1'b1, 1'b1);
      axi_rd(`EHM_OFF_RES_LO, p[31:0], ok);
      axi_rd(`EHM_OFF_RES_HI, {23'h0, 1'b1, 4'h0, p[35:32]}, ok);
      axi_rd(4'hc, 32'h0, err);
      axi_wr(`EHM_OFF_RES_LO, 32'h1, err);
      axi_rd(`EHM_OFF_CTRL, 32'h40, ok);
      // Byte lane 0 off: the write is answered but leaves the selects
      wstrb <= 4'h0;
      axi_wr(`EHM_OFF_CTRL, 32'h41, ok);
      wstrb <= 4'hf;
      axi_rd(`EHM_OFF_CTRL, 32'h40, ok);
      axi_wr(`EHM_OFF_CTRL, 32'h41, ok);
      for (i = 0; i < 4; i++) begin
         fab_u.drive(a2, b2, i[1], i[0]);
         #1;
         p = {np(a2[17:9], b2[17:9], i[1], i[0]),
              np(a2[8:0], b2[8:0], i[1], i[0])};
         chk(result, p);
         chk(36'(result_signed), 36'(i[1] | i[0]));
      end
      // Dual lanes through the result stage only
      axi_wr(`EHM_OFF_CTRL, 32'h61, ok);
      fab_u.drive(a2, b2, 1'b1, 1'b0);
      @(posedge aclk);
      #1;
      p = {np(a2[17:9], b2[17:9], 1'b1, 1'b0),
           np(a2[8:0], b2[8:0], 1'b1, 1'b0)};
      chk(result, p);
      chk(36'(result_signed), 36'h1);
      // Operand A registered, B straight through
      axi_wr(`EHM_OFF_CTRL, 32'h42, ok);
      fab_u.drive(a1, b1, 1'b1, 1'b1);
      #1;
      chk(result, wp(a2, b1, 1'b1, 1'b1));
      @(posedge aclk);
      #1;
      chk(result, wp(a1, b1, 1'b1, 1'b1));
      // Every stage registered, signs change on back-to-back operands
      axi_wr(`EHM_OFF_CTRL, 32'h7e, ok);
      fab_u.drive(a1, b1, 1'b1, 1'b0);
      fab_u.drive(a2, b2, 1'b0, 1'b1);
      @(posedge aclk);
      #1;
      chk(result, wp(a1, b1, 1'b1, 1'b0));
      chk(36'(result_signed), 36'h1);
      @(posedge aclk);
      #1;
      chk(result, wp(a2, b2, 1'b0, 1'b1));
      @(posedge aclk);
      ce <= 1'b0;
      fab_u.drive(a1, b1, 1'b0, 1'b0);
      repeat (3) @(posedge aclk);
      #1;
      chk(result, wp(a2, b2, 1'b0, 1'b1));
      // Clear acts with the enable low, so no edge can be the cause
      @(posedge aclk);
      clear <= 1'b1;
      #1;
      chk(result, 36'h0);
      chk(36'(result_signed), 36'h0);
      @(posedge aclk);
      clear <= 1'b0;
      ce <= 1'b1;
      repeat (2) @(posedge aclk);
      #1;
      chk(result, wp(a1, b1, 1'b0, 1'b0));
      report_and_stop();
   end
endmodule
